// ---- rtl/pmdc_ctrl.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "pmdc_defs.svh"

// Operation
// - Four banks, 256K x 32, own strobes
// - Refresh is CAS-before-RAS, no address counter
// - Refresh starts from idle after a rising host refresh acknowledge
// - Single read and write data in 3 clocks
// - Cycle spacing 6 read, 5 write, 2 page
// - Page burst: first 3 clocks, then 2
// - Banks map 400000-4FFFFF in 256K steps
// - Open a row only inside board select range
// - A18 and A19 choose the strobe pair
// - Strobe low keeps row, cycles column on reads
// - Strobe high releases row and column
// - Column mux switches fixed delay after row
// - Clocked from delayed processor output clock
module pmdc_ctrl
    import pmdc_pkg::*;
(
    input  wire logic        SYS_CLK,
    input  wire logic        RESET,
    input  wire logic        PROCESSOR_STROBE_N,
    input  wire logic        CPU_READ,
    input  wire logic [23:0] CPU_ADDR,
    input  wire logic        HOST_REFRESH_ACK,
    output logic             CPU_READY_N,
    output logic [3:0]       DRAM_RAS_N,
    output logic [3:0]       DRAM_CAS_N,
    output logic [8:0]       DRAM_ADDR,
    output logic             DRAM_WE_N,
    output logic             REFRESH_BUSY
);

    pmdc_req_t   req;
    pmdc_dram_t  dram_q;
    pmdc_state_t state_q;
    logic [2:0]  cnt_q;
    logic [1:0]  bank_q;
    logic [8:0]  col_q;
    logic        write_q;
    logic        ref_pend_q;
    logic        ref_ack_q;
    logic        ready_q;
    logic        board_sel;
    logic        use_column;
    logic        row_active;
    logic        new_col;
    logic [23:0] last_addr_q;

    assign req.strobe_n = PROCESSOR_STROBE_N;
    assign req.read     = CPU_READ;
    assign req.addr     = CPU_ADDR;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // SYS_CLK is the delayed copy of cpu_output_clock
    assign board_sel = (req.addr[`PMDC_BOARD_HI_MSB:`PMDC_BOARD_HI_LSB]
                        == `PMDC_BOARD_TAG);
    // A new page-mode column: strobe held, read, address moved
    assign new_col = !req.strobe_n && req.read
                     && (req.addr != last_addr_q);
    assign row_active = (dram_q.ras_n != 4'hF);

    pmdc_mux_delay u_mux (
        .SYS_CLK    (SYS_CLK),
        .RESET      (RESET),
        .ROW_ACTIVE (row_active && (state_q == PMDC_ROW)),
        .USE_COLUMN (use_column)
    );

    // ------------------------------------------------------------
    // Refresh request capture
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            ref_ack_q  <= 1'b0;
            ref_pend_q <= 1'b0;
        end else begin
            ref_ack_q <= HOST_REFRESH_ACK;
            // Set wins over the clear on service start
            if (HOST_REFRESH_ACK && !ref_ack_q) begin
                ref_pend_q <= 1'b1;
            end else if (state_q == PMDC_REF_CAS && cnt_q == 3'h0) begin
                ref_pend_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Timing state machine
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            state_q     <= PMDC_IDLE;
            cnt_q       <= 3'h0;
            bank_q      <= 2'h0;
            col_q       <= 9'h000;
            write_q     <= 1'b0;
            ready_q     <= 1'b0;
            last_addr_q <= 24'h000000;
            dram_q      <= '{ras_n: 4'hF, cas_n: 4'hF,
                             ma: 9'h000, we_n: 1'b1};
        end else begin
            ready_q <= 1'b0;
            case (state_q)
                PMDC_IDLE: begin
                    cnt_q <= 3'h0;
                    if (ref_pend_q) begin
                        // CAS before RAS on all banks
                        dram_q.cas_n <= 4'h0;
                        state_q      <= PMDC_REF_CAS;
                    end else if (!req.strobe_n && board_sel) begin
                        bank_q  <= req.addr[`PMDC_BANK_MSB:`PMDC_BANK_LSB];
                        col_q   <= req.addr[`PMDC_COL_MSB:`PMDC_COL_LSB];
                        write_q <= !req.read;
                        last_addr_q <= req.addr;
                        dram_q.ma   <= req.addr[`PMDC_ROW_MSB:`PMDC_ROW_LSB];
                        // One strobe pair per bank
                        dram_q.ras_n <= ~(4'h1 <<
                            req.addr[`PMDC_BANK_MSB:`PMDC_BANK_LSB]);
                        dram_q.we_n  <= req.read;
                        state_q      <= PMDC_ROW;
                    end
                end
                PMDC_ROW: begin
                    if (use_column) begin
                        dram_q.ma    <= col_q;
                        dram_q.cas_n <= ~(4'h1 << bank_q);
                        ready_q      <= 1'b1;
                        state_q      <= PMDC_COL;
                    end
                end
                PMDC_COL: begin
                    if (req.strobe_n) begin
                        // Release the row for precharge
                        dram_q.ras_n <= 4'hF;
                        dram_q.cas_n <= 4'hF;
                        dram_q.we_n  <= 1'b1;
                        cnt_q   <= write_q ? `PMDC_PRECHARGE - 3'd1
                                           : `PMDC_PRECHARGE;
                        state_q <= PMDC_PRECH;
                    end else if (new_col && !write_q) begin
                        // Page hit: lift CAS, present new column
                        dram_q.cas_n <= 4'hF;
                        dram_q.ma    <= req.addr[`PMDC_COL_MSB:`PMDC_COL_LSB];
                        last_addr_q  <= req.addr;
                        state_q      <= PMDC_PAGE;
                    end
                end
                PMDC_PAGE: begin
                    // Second clock of a 2-clock page access
                    dram_q.cas_n <= ~(4'h1 << bank_q);
                    ready_q      <= 1'b1;
                    state_q      <= PMDC_COL;
                end
                PMDC_PRECH: begin
                    if (cnt_q <= 3'h1) begin
                        state_q <= PMDC_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 3'h1;
                    end
                end
                PMDC_REF_CAS: begin
                    dram_q.ras_n <= 4'h0;
                    cnt_q        <= `PMDC_REFRESH_CLKS;
                    state_q      <= PMDC_REF_RAS;
                end
                PMDC_REF_RAS: begin
                    if (cnt_q == 3'h1) begin
                        dram_q.ras_n <= 4'hF;
                        dram_q.cas_n <= 4'hF;
                        cnt_q        <= `PMDC_PRECHARGE;
                        state_q      <= PMDC_PRECH;
                    end else begin
                        cnt_q <= cnt_q - 3'h1;
                    end
                end
                default: begin
                    state_q <= PMDC_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign DRAM_RAS_N   = dram_q.ras_n;
    assign DRAM_CAS_N   = dram_q.cas_n;
    assign DRAM_ADDR    = dram_q.ma;
    assign DRAM_WE_N    = dram_q.we_n;
    assign CPU_READY_N  = !ready_q;
    assign REFRESH_BUSY = (state_q == PMDC_REF_CAS)
                          || (state_q == PMDC_REF_RAS);

endmodule
`default_nettype wire

// ---- rtl/pmdc_defs.svh ----
`ifndef PMDC_DEFS_SVH
`define PMDC_DEFS_SVH

// ----------------------------------------------------------------
// Address decode
// ----------------------------------------------------------------
`define PMDC_BOARD_BASE   8'h40
`define PMDC_BOARD_HI_MSB 23
`define PMDC_BOARD_HI_LSB 20
`define PMDC_BOARD_TAG    4'h4
`define PMDC_BANK_MSB     19
`define PMDC_BANK_LSB     18
`define PMDC_ROW_MSB      17
`define PMDC_ROW_LSB      9
`define PMDC_COL_MSB      8
`define PMDC_COL_LSB      0

// ----------------------------------------------------------------
// Timing, in clocks of the controller clock
// ----------------------------------------------------------------
`define PMDC_ACCESS_CLKS  3'd3
`define PMDC_PAGE_CLKS    3'd2
`define PMDC_READ_CYCLE   3'd5
`define PMDC_WRITE_CYCLE  3'd4
`define PMDC_MUX_DELAY    3'd1
`define PMDC_PRECHARGE    3'd2
`define PMDC_REFRESH_CLKS 3'd4

`endif

// ---- rtl/pmdc_mux_delay.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "pmdc_defs.svh"

// Fixed delay after the row strobe that flips the address mux
module pmdc_mux_delay
    import pmdc_pkg::*;
(
    input  wire logic SYS_CLK,
    input  wire logic RESET,
    input  wire logic ROW_ACTIVE,
    output logic      USE_COLUMN
);

    logic [2:0] cnt_q;

    // ------------------------------------------------------------
    // Delay counter
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (RESET || !ROW_ACTIVE) begin
            cnt_q <= 3'h0;
        end else if (cnt_q != `PMDC_MUX_DELAY) begin
            cnt_q <= cnt_q + 3'h1;
        end
    end

    // Column once the delay has run out
    assign USE_COLUMN = ROW_ACTIVE && (cnt_q == `PMDC_MUX_DELAY);

endmodule
`default_nettype wire

// ---- rtl/pmdc_pkg.sv ----
package pmdc_pkg;

    // Processor bus request as seen by the controller
    typedef struct packed {
        logic        strobe_n;
        logic        read;
        logic [23:0] addr;
    } pmdc_req_t;

    // Strobes to the DRAM array, one pair per bank
    typedef struct packed {
        logic [3:0] ras_n;
        logic [3:0] cas_n;
        logic [8:0] ma;
        logic       we_n;
    } pmdc_dram_t;

    typedef enum logic [2:0] {
        PMDC_IDLE,
        PMDC_ROW,
        PMDC_COL,
        PMDC_PAGE,
        PMDC_PRECH,
        PMDC_REF_CAS,
        PMDC_REF_RAS
    } pmdc_state_t;

endpackage

// ---- verif/pmdc_ctrl_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
module pmdc_ctrl_asserts
    import pmdc_pkg::*;
(
    input wire logic        SYS_CLK,
    input wire logic        RESET,
    input wire logic        PROCESSOR_STROBE_N,
    input wire logic        CPU_READ,
    input wire logic [23:0] CPU_ADDR,
    input wire logic        HOST_REFRESH_ACK,
    input wire logic        CPU_READY_N,
    input wire logic [3:0]  DRAM_RAS_N,
    input wire logic [3:0]  DRAM_CAS_N,
    input wire logic [8:0]  DRAM_ADDR,
    input wire logic        DRAM_WE_N,
    input wire logic        REFRESH_BUSY
);
    // ----------------------------------------
    // Access timing and strobes
    // ----------------------------------------
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RESET);
    wire in_rng = CPU_ADDR[23:20] == 4'h4;
    wire quiet  = !REFRESH_BUSY;
    wire open_r = DRAM_RAS_N != 4'hF && DRAM_RAS_N != 4'h0;
    property p_access;
        ($fell(PROCESSOR_STROBE_N) && in_rng && DRAM_RAS_N == 4'hF && quiet)
        |-> ##[2:3] !CPU_READY_N;
    endproperty
    property p_out;
        (!PROCESSOR_STROBE_N && !in_rng) [*4] |-> CPU_READY_N;
    endproperty
    property p_bank;
        (open_r && quiet) |-> DRAM_RAS_N == ~(4'h1 << CPU_ADDR[19:18]);
    endproperty
    property p_release;
        ($rose(PROCESSOR_STROBE_N) && quiet)
        |=> {DRAM_RAS_N, DRAM_CAS_N} == 8'hFF;
    endproperty
    property p_hold;
        (!PROCESSOR_STROBE_N && open_r) |=> DRAM_RAS_N != 4'hF;
    endproperty
    property p_refresh;
        $rose(HOST_REFRESH_ACK) |-> ##[1:40] REFRESH_BUSY;
    endproperty
    property p_cbr;
        DRAM_RAS_N == 4'h0 |-> $past(DRAM_CAS_N) == 4'h0;
    endproperty
    property p_col;
        (DRAM_CAS_N != 4'hF && DRAM_CAS_N != 4'h0)
        |-> DRAM_ADDR == $past(CPU_ADDR[8:0]);
    endproperty
    a_access: assert property (p_access) else $error("late ready");
    a_out: assert property (p_out) else $error("ready off board");
    a_bank: assert property (p_bank) else $error("wrong bank");
    a_release: assert property (p_release) else $error("no release");
    a_hold: assert property (p_hold) else $error("row dropped");
    a_refresh: assert property (p_refresh) else $error("no refresh");
    a_cbr: assert property (p_cbr) else $error("ras before cas");
    a_col: assert property (p_col) else $error("bad column");
    c_page: cover property (!CPU_READY_N ##2 !CPU_READY_N);
    c_ref: cover property (REFRESH_BUSY && DRAM_RAS_N == 4'h0);
    c_write: cover property (!DRAM_WE_N && !CPU_READY_N);
endmodule
bind pmdc_ctrl pmdc_ctrl_asserts u_chk (.SYS_CLK(SYS_CLK), .RESET(RESET),
    .PROCESSOR_STROBE_N(PROCESSOR_STROBE_N), .CPU_READ(CPU_READ),
    .CPU_ADDR(CPU_ADDR), .HOST_REFRESH_ACK(HOST_REFRESH_ACK),
    .CPU_READY_N(CPU_READY_N), .DRAM_RAS_N(DRAM_RAS_N),
    .DRAM_CAS_N(DRAM_CAS_N), .DRAM_ADDR(DRAM_ADDR),
    .DRAM_WE_N(DRAM_WE_N), .REFRESH_BUSY(REFRESH_BUSY));
`default_nettype wire

// ---- verif/pmdc_dram_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module pmdc_dram_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [3:0] ras_n,
    input  wire logic [3:0] cas_n,
    output logic [7:0]      hits
);
    logic idle_q;
    // Count column strobes against an open row
    always_ff @(posedge clk) begin
        if (rst)
            hits <= 8'h00;
        else if (cas_n != 4'hF && idle_q && ras_n != 4'hF)
            hits <= hits + 8'h01;
        idle_q <= &cas_n;
    end
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb
    import pmdc_pkg::*;
;
    logic clk, rst, ack, rdy_n, we_n, rb;
    logic [3:0] ras_n, cas_n;
    logic [8:0] ma;
    logic [7:0] hits;
    pmdc_req_t req;
    int fail_count = 0;
    int num_checks = 0;
    // Clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    pmdc_ctrl dut (.SYS_CLK(clk), .RESET(rst), .PROCESSOR_STROBE_N(req.strobe_n),
        .CPU_READ(req.read), .CPU_ADDR(req.addr), .HOST_REFRESH_ACK(ack),
        .CPU_READY_N(rdy_n), .DRAM_RAS_N(ras_n), .DRAM_CAS_N(cas_n),
        .DRAM_ADDR(ma), .DRAM_WE_N(we_n), .REFRESH_BUSY(rb));
    pmdc_dram_model mem (.clk(clk), .rst(rst), .ras_n(ras_n), .cas_n(cas_n),
        .hits(hits));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task test_done;
        $display("checks=%0d fails=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Processor waits on ready, bounded
    task wait_rdy(output int n);
        n = 0;
        do begin @(negedge clk); n++; end while (rdy_n !== 1'b0 && n < 12);
    endtask
    task t_single(input logic rd);
        int n;
        logic [3:0] e;
        for (int b = 0; b < 4; b++) begin
            req = '{1'b0, rd, {4'h4, 2'(b), 18'h00205}};
            e = ~(4'h1 << b);
            wait_rdy(n);
            chk(n, 3);
            chk(ras_n, e);
            chk(ma, 9'h005);
            chk(we_n, rd);
            req.strobe_n = 1'b1;
            @(negedge clk);
            chk({ras_n, cas_n}, 8'hFF);
            repeat (4) @(negedge clk);
        end
    endtask
    task t_page;
        int n;
        logic [7:0] h;
        h = hits;
        req = '{1'b0, 1'b1, 24'h480010};
        wait_rdy(n);
        chk(n, 3);
        for (int i = 1; i < 4; i++) begin
            req.addr = 24'h480010 + 24'(i);
            wait_rdy(n);
            chk(n, 2);
            chk(ras_n, 4'hB);
        end
        req.strobe_n = 1'b1;
        repeat (4) @(negedge clk);
        chk(hits - h, 8'h04);
    endtask
    task t_out;
        logic seen;
        seen = 1'b0;
        req = '{1'b0, 1'b1, 24'h500000};
        repeat (8) begin
            @(negedge clk);
            seen |= !rdy_n || ras_n != 4'hF;
        end
        chk(seen, 1'b0);
        req.strobe_n = 1'b1;
        @(negedge clk);
    endtask
    task t_refresh;
        int n;
        logic cbr;
        cbr = 1'b0;
        req = '{1'b0, 1'b1, 24'h4C0100};
        ack = 1'b1;
        @(negedge clk);
        ack = 1'b0;
        wait_rdy(n);
        chk(rb, 1'b0);
        req.strobe_n = 1'b1;
        repeat (30) begin
            @(negedge clk);
            cbr |= ras_n == 4'h0 && cas_n == 4'h0;
        end
        chk(cbr, 1'b1);
        chk(rb, 1'b0);
    endtask
    // Main sequence
    initial begin
        req = '{1'b1, 1'b1, 24'h000000};
        ack = 1'b0;
        rst = 1'b1;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        t_single(1'b1);
        t_single(1'b0);
        t_page;
        t_out;
        t_refresh;
        test_done;
    end
    // Watchdog
    initial begin
        #20000;
        fail_count++;
        test_done;
    end
endmodule
`default_nettype wire
